// ### hdl/fp_break_consts.svh
// constants for the floating-point error / pending break output
// assumes inclusion by bare name from the hdl folder
`ifndef FP_BREAK_CONSTS_SVH
`define FP_BREAK_CONSTS_SVH

// pin levels, all pins active low
`define PIN_ASSERTED   1'h0
`define PIN_DEASSERTED 1'h1

// status flag level out of reset
`define FLAG_CLEAR     1'h0

// synchroniser depth for pin inputs
`define SYNC_DEPTH     3
`define SYNC_LAST      2
`define SYNC_CLEAR     3'h7

`endif

// ### hdl/fp_break_pkg.sv
// types for the floating-point error / pending break output
// assumes nothing beyond a SystemVerilog compiler
package fp_break_pkg;

   // line meaning: error report, stop-clock idle, break pending
   typedef enum logic [1:0]
   {
      ST_RUN,
      ST_STOP,
      ST_BREAK
   } mode_type;

endpackage : fp_break_pkg

// ### hdl/pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clk and idles high
`include "fp_break_consts.svh"

module pin_sync
(
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   // pin side
   input  wire logic pin_n,
   // clock domain side
   output logic      level_n
);

   logic [`SYNC_DEPTH-1:0] stage_r;

   // shift chain, first stage read only by the second
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         stage_r <= `SYNC_CLEAR;
      else if (clk_en)
         stage_r <= {stage_r[`SYNC_DEPTH-2:0], pin_n};
   end

   // accept a change once stages two and three agree
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         level_n <= `PIN_DEASSERTED;
      else if (clk_en && (stage_r[`SYNC_LAST] == stage_r[`SYNC_LAST-1]))
         level_n <= stage_r[`SYNC_LAST];
   end

endmodule : pin_sync

// ### hdl/fp_error_break_event_signal.sv
// multiplexed floating-point error / pending break event output
// assumes stop-clock and probe requests arrive as asynchronous pins;
// fp error, mask and break source come from logic on clk
`include "fp_break_consts.svh"

module fp_error_break_event_signal
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   // pins from core logic
   input  wire logic              stop_clock_request_n,
   input  wire logic              probe_request_n,
   // floating-point unit and break sources
   input  wire logic              fp_error_flag,
   input  wire logic              fp_error_mask,
   input  wire logic              break_event_source,
   // pin to core logic
   output logic                   fp_error_break_event_out_n,
   // status
   output fp_break_pkg::mode_type line_mode,
   output logic                   pending_break_indication,
   output logic                   fp_error_indication
);

   import fp_break_pkg::*;

   logic     stop_sync_n;
   logic     probe_sync_n;
   logic     stop_act;
   logic     probe_act;
   logic     fp_unmasked;
   logic     break_evt;
   mode_type state_r;
   mode_type state_nxt;
   logic     out_n_r;
   logic     out_n_nxt;

   // active low pin decode
   function automatic logic pin_active(input logic level_n);
      pin_active = (level_n == `PIN_ASSERTED);
   endfunction : pin_active

   // pin synchronisers
   pin_sync u_stop_sync
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .pin_n   (stop_clock_request_n),
      .level_n (stop_sync_n)
   );

   pin_sync u_probe_sync
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .pin_n   (probe_request_n),
      .level_n (probe_sync_n)
   );

   assign stop_act    = pin_active(stop_sync_n);
   assign probe_act   = pin_active(probe_sync_n);

   assign fp_unmasked = fp_error_flag && !fp_error_mask;

   assign break_evt   = break_event_source || probe_act;

   // mode sequencing
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RUN:
         begin
            if (stop_act && break_evt)
               state_nxt = ST_BREAK;
            else if (stop_act)
               state_nxt = ST_STOP;
         end
         ST_STOP:
         begin
            if (!stop_act)
               state_nxt = ST_RUN;
            else if (break_evt)
               state_nxt = ST_BREAK;
         end
         ST_BREAK:
         begin
            if (!stop_act)
               state_nxt = ST_RUN;
         end
         default:
            state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         state_r <= ST_RUN;
      else if (clk_en)
         state_r <= state_nxt;
   end

   // output meaning per mode
   always_comb
   begin
      out_n_nxt = `PIN_DEASSERTED;
      unique case (state_nxt)
         ST_RUN:
            out_n_nxt = fp_unmasked ? `PIN_ASSERTED : `PIN_DEASSERTED;
         ST_STOP:
            out_n_nxt = `PIN_DEASSERTED;
         ST_BREAK:
            out_n_nxt = `PIN_ASSERTED;
         default:
            out_n_nxt = `PIN_DEASSERTED;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         out_n_r <= `PIN_DEASSERTED;
      else if (clk_en)
         out_n_r <= out_n_nxt;
   end

   // status flags
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pending_break_indication <= `FLAG_CLEAR;
         fp_error_indication      <= `FLAG_CLEAR;
      end
      else if (clk_en)
      begin
         pending_break_indication <= (state_nxt == ST_BREAK);
         fp_error_indication      <= (state_nxt == ST_RUN) && fp_unmasked;
      end
   end

   assign fp_error_break_event_out_n = out_n_r;
   assign line_mode                  = state_r;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_fp_error_shown: assert property (clk_en && !stop_act && fp_unmasked |=> !out_n_r)
      else $error("unmasked fp error not shown on output");

   a_idle_high_level: assert property (clk_en && !stop_act && !fp_unmasked |=> out_n_r)
      else $error("output low with nothing to report");

   a_fp_flag_status: assert property
      (clk_en && !stop_act && fp_unmasked |=> fp_error_indication)
      else $error("unmasked fp error not flagged");

   a_stop_quiet_output: assert property
      (clk_en && stop_act && !break_evt && state_r != ST_BREAK |=> out_n_r)
      else $error("output low during stop-clock without break");

   a_stop_no_flag: assert property
      (clk_en && stop_act |=> !fp_error_indication)
      else $error("fp error flagged during stop-clock");

   a_run_no_break: assert property
      (clk_en && !stop_act |=> !pending_break_indication && state_r == ST_RUN)
      else $error("break pending outside stop-clock");

   a_break_held_stop: assert property
      (clk_en && state_r == ST_BREAK && stop_act |=> !out_n_r && state_r == ST_BREAK)
      else $error("break indication dropped during stop-clock");

   a_break_flag_held: assert property
      (clk_en && state_r == ST_BREAK && stop_act |=> pending_break_indication)
      else $error("pending flag dropped during stop-clock");

   a_break_release_end: assert property
      (clk_en && state_r == ST_BREAK && !stop_act |=> state_r == ST_RUN)
      else $error("break not released after stop-clock end");

   a_probe_break_event: assert property
      (clk_en && stop_act && probe_act |=> !out_n_r && pending_break_indication)
      else $error("probe during stop-clock gave no break");

   // pin probe during stop-clock reaches output in bounded time
   a_probe_pin_latency: assert property
      ((clk_en && stop_clock_request_n == `PIN_ASSERTED
        && probe_request_n == `PIN_ASSERTED) [*6] |-> !out_n_r)
      else $error("probe pin not seen within six cycles");

   c_fp_error_report: cover property (!stop_act && fp_unmasked ##1 !out_n_r);
   c_fp_masked: cover property (!stop_act && fp_error_flag && fp_error_mask ##1 out_n_r);
   c_probe_break: cover property (state_r == ST_STOP && probe_act ##1 state_r == ST_BREAK);
   c_source_break: cover property (state_r == ST_STOP && break_event_source && !probe_act);
   c_break_exit: cover property (state_r == ST_BREAK ##1 state_r == ST_RUN);

endmodule : fp_error_break_event_signal

// ### tb/core_logic_model.sv
// core logic model driving the stop-clock and probe pins
// assumes the bench pulses stop_go and holds probe_go for whole cycles
module core_logic_model
(
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // bench commands
   input  wire logic stop_go,
   input  wire logic probe_go,
   // pins
   input  wire logic fp_error_break_event_out_n,
   output logic      stop_clock_request_n,
   output logic      probe_request_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] low_cnt_r;
   // end stop-clock on low break pin
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stop_clock_request_n <= 1'h1;
         low_cnt_r            <= 4'h0;
      end
      else if (stop_go)
         stop_clock_request_n <= 1'h0;
      else if (!stop_clock_request_n && !fp_error_break_event_out_n)
      begin
         low_cnt_r <= low_cnt_r + 4'h1;
         if (low_cnt_r == 4'h8)
         begin
            stop_clock_request_n <= 1'h1;
            low_cnt_r            <= 4'h0;
         end
      end
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         probe_request_n <= 1'h1;
      else
         probe_request_n <= !probe_go;
   end
endmodule : core_logic_model

// ### tb/test_fp_error_break_event_signal.sv
// self-checking bench for the fp error / break event output
// assumes the core logic model in tb/ and the design under hdl/
module test_fp_error_break_event_signal;
   timeunit 1ns;
   timeprecision 1ps;
   import fp_break_pkg::*;
   logic     clk = 0, sys_rst = 1, clk_en = 1, stop_go = 0, probe_go = 0;
   logic     fp_error_flag = 0, fp_error_mask = 0, break_event_source = 0;
   logic     stop_n, probe_n, out_n, pend, fp_ind;
   mode_type mode;
   int       errors = 0, compares = 0;
   core_logic_model core_logic_model_i (.clk(clk), .sys_rst(sys_rst), .stop_go(stop_go),
      .probe_go(probe_go), .fp_error_break_event_out_n(out_n),
      .stop_clock_request_n(stop_n), .probe_request_n(probe_n));
   fp_error_break_event_signal fp_error_break_event_signal_i (.clk(clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .stop_clock_request_n(stop_n), .probe_request_n(probe_n),
      .fp_error_flag(fp_error_flag), .fp_error_mask(fp_error_mask),
      .break_event_source(break_event_source), .fp_error_break_event_out_n(out_n),
      .line_mode(mode), .pending_break_indication(pend), .fp_error_indication(fp_ind));
   initial forever #2.5 clk = ~clk;
   task end_of_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task check(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task check_mode(input mode_type got, input mode_type exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_mode
   task wait_out(input logic lvl);
      int n;
      n = 0;
      while (out_n !== lvl && n < 40)
      begin
         tick(1);
         n++;
      end
      if (out_n !== lvl)
      begin
         errors++;
         end_of_test();
      end
   endtask : wait_out
   task start_stop;
      @(posedge clk);
      stop_go <= 1;
      @(posedge clk);
      stop_go <= 0;
      tick(8);
   endtask : start_stop
   task fp_error_run;
      @(posedge clk);
      fp_error_flag <= 1;
      tick(1);
      check(out_n, 1'h0);
      check(fp_ind, 1'h1);
      fp_error_mask <= 1;
      tick(1);
      check(out_n, 1'h1);
      fp_error_flag <= 0;
      fp_error_mask <= 0;
      tick(1);
   endtask : fp_error_run
   task freeze_run;
      clk_en <= 0;
      fp_error_flag <= 1;
      tick(3);
      check(out_n, 1'h1);
      clk_en <= 1;
      tick(1);
      check(out_n, 1'h0);
      fp_error_flag <= 0;
      tick(1);
      check(out_n, 1'h1);
   endtask : freeze_run
   task source_break;
      start_stop();
      check_mode(mode, ST_STOP);
      fp_error_flag <= 1;
      tick(3);
      check(out_n, 1'h1);
      fp_error_flag <= 0;
      break_event_source <= 1;
      tick(1);
      break_event_source <= 0;
      wait_out(1'h0);
      check(pend, 1'h1);
      tick(3);
      check(out_n, 1'h0);
      wait_out(1'h1);
      check_mode(mode, ST_RUN);
   endtask : source_break
   task probe_break;
      @(posedge clk);
      probe_go <= 1;
      tick(3);
      probe_go <= 0;
      tick(8);
      check(out_n, 1'h1);
      start_stop();
      probe_go <= 1;
      tick(7);
      probe_go <= 0;
      wait_out(1'h0);
      check_mode(mode, ST_BREAK);
      tick(4);
      check(out_n, 1'h0);
      wait_out(1'h1);
      check(stop_n, 1'h1);
   endtask : probe_break
   initial
   begin
      tick(2);
      sys_rst <= 0;
      tick(2);
      check(out_n, 1'h1);
      fp_error_run();
      freeze_run();
      source_break();
      probe_break();
      end_of_test();
   end
endmodule : test_fp_error_break_event_signal
